// >>> verilog/capreg_pkg.sv
// constants and types for the capability register slice
package capreg_pkg;
    localparam logic [7:0] OFS_SMEM = 8'hBC;
    localparam logic [7:0] OFS_HDR = 8'hC0;
    localparam logic [7:0] OFS_DEVCAP = 8'hC4;
    localparam logic [7:0] OFS_OVR = 8'hD0;
    localparam logic [7:0] OFS_SPL = 8'hD4;
    localparam int START_BIT = 0;
    localparam int CMD_BIT = 1;
    localparam int ADDR_LSB = 9;
    localparam int DATA_LSB = 16;
    localparam logic [7:0] CAP_ID = 8'h10;
    localparam logic [7:0] NEXT_PTR = 8'h00;
    localparam logic [3:0] CAP_VER = 4'h2;
    localparam logic [3:0] TYPE_UP = 4'h5;
    localparam logic [3:0] TYPE_DOWN = 4'h6;
    localparam logic [2:0] MPS_SMALL = 3'h1;
    localparam logic [2:0] MPS_LARGE = 3'h2;
    localparam logic [2:0] LAT_RESET = 3'h0;
    localparam logic [15:0] DATA_RESET = 16'h0000;
    localparam logic [6:0] ADDR_RESET = 7'h00;
    localparam logic [7:0] SPL_VAL_RESET = 8'h00;
    localparam logic [1:0] SPL_SCL_RESET = 2'h0;

    typedef enum logic [1:0] {
        ST_INIT = 2'b00,
        ST_IDLE = 2'b01,
        ST_MEM = 2'b10
    } mem_state_e;

    // defaults that SMBus or autoload may replace
    typedef struct packed {
        logic slot;
        logic [2:0] mps;
        logic rber;
    } ovr_s;

    // request to and answer from the serial memory engine
    typedef struct packed {
        logic start;
        logic write;
        logic [6:0] addr;
        logic [15:0] data;
    } mem_req_s;

    typedef struct packed {
        logic done;
        logic [15:0] data;
    } mem_rsp_s;

    typedef struct packed {
        mem_state_e st;
        logic start;
        logic cmd;
        logic [6:0] addr;
        logic [15:0] data;
        ovr_s ovr;
        logic [7:0] spl_val;
        logic [1:0] spl_scl;
        logic [31:0] rdata;
        logic ack;
    } state_s;
endpackage

// >>> verilog/capreg_bank.sv
// capability register slice with serial memory data field
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
// Operation
// - data field bits 31:16 read-write, reset zero, holds write data.
// - completed memory read loads the data field with fetched word.
// - header low byte reads 10h, read-only.
// - next pointer byte reads 00h, read-only.
// - capability version reads 0010b, read-only.
// - port type reads 0101b upstream, 0110b downstream.
// - slot bit resets to strap level; SMBus or autoload may replace.
// - interrupt message number always reads zero.
// - payload supported resets 001b or 010b by strap; replaceable.
// - phantom functions field always reads 00b.
// - extended tag supported bit always reads zero.
// - L0s latency field read-only, resets 000b.
// - L1 latency field read-only, resets 000b.
// - role-based error bit resets one; SMBus or autoload may replace.
// - upstream captured power value resets 00h, set by message.
// - upstream captured power scale resets 00b, set by message.
// - start bit launches cycle; command bit chooses read or write.
// - 7-bit word address held read-write in same dword, reset zero.
module capreg_bank
    import capreg_pkg::*;
#(
    parameter bit UPSTREAM = 1'b1,
    parameter int ADDR_W = 8
)(
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic [ADDR_W-1:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [31:0] writedata_i,
    input wire logic [3:0] byteenable_i,
    output logic [31:0] readdata_o,
    output logic waitrequest_o,
    input wire logic slot_present_strap_i,
    input wire logic large_payload_strap_i,
    input wire logic ovr_valid_i,
    input wire ovr_s ovr_i,
    input wire logic spl_msg_valid_i,
    input wire logic [9:0] spl_msg_payload_i,
    output mem_req_s mem_req_o,
    input wire mem_rsp_s mem_rsp_i,
    input wire logic mem_ready_i
);
    // offsets need at least one full byte of address
    if (ADDR_W < 8)
    begin : g_addr_check
        $error("ADDR_W must be at least 8");
    end

    state_s q;
    state_s d;
    logic [31:0] hdr;
    logic [31:0] devcap;
    logic [31:0] smem;
    logic hit;
    logic [7:0] a;
    logic req;
    logic commit;
    logic sel_smem;
    logic sel_hdr;
    logic sel_devcap;
    logic sel_ovr;
    logic smem_free;
    logic [31:0] lane_wdata;
    logic [31:0] rd_word;

    assign a = address_i[7:0];
    assign hit = (address_i[ADDR_W-1:0] >> 8) == '0;
    assign req = read_i || write_i;
    // a write lands one edge after its wait ends, in the cycle that q.ack is high
    assign commit = write_i && q.ack && hit;
    assign sel_smem = (a == OFS_SMEM);
    assign sel_hdr = (a == OFS_HDR);
    assign sel_devcap = (a == OFS_DEVCAP);
    assign sel_ovr = (a == OFS_OVR);
    // no rewrite while a memory cycle runs or is being launched
    assign smem_free = (q.st == ST_IDLE) && !(q.start && mem_ready_i);

    // byte lanes merged over the current data dword
    for (genvar i = 0; i < 4; i++)
    begin : g_lane
        assign lane_wdata[i*8 +: 8] = byteenable_i[i]
            ? writedata_i[i*8 +: 8] : smem[i*8 +: 8];
    end

    // read mux; reserved and unmapped offsets read zero
    always_comb
    begin
        rd_word = 32'h0000_0000;
        if (!hit)
        begin
            rd_word = 32'h0000_0000;
        end
        else if (sel_smem)
        begin
            rd_word = smem;
        end
        else if (sel_hdr)
        begin
            rd_word = hdr;
        end
        else if (sel_devcap)
        begin
            rd_word = devcap;
        end
        else if (sel_ovr)
        begin
            rd_word = {27'h0, q.ovr};
        end
    end

    always_comb
    begin
        // header, capability and data words from fixed and held fields
        // identifier value
        hdr[7:0] = CAP_ID;
        hdr[15:8] = NEXT_PTR;
        hdr[19:16] = CAP_VER;
        hdr[23:20] = UPSTREAM ? TYPE_UP : TYPE_DOWN;
        hdr[24] = q.ovr.slot;
        hdr[29:25] = 5'h00;
        hdr[31:30] = 2'h0;
        devcap[2:0] = q.ovr.mps;
        devcap[4:3] = 2'h0;
        devcap[5] = 1'b0;
        devcap[8:6] = LAT_RESET;
        devcap[11:9] = LAT_RESET;
        devcap[14:12] = 3'h0;
        devcap[15] = q.ovr.rber;
        devcap[17:16] = 2'h0;
        devcap[25:18] = q.spl_val;
        devcap[27:26] = q.spl_scl;
        devcap[31:28] = 4'h0;
        smem = {q.data, q.addr, 7'h00, q.cmd, q.start};
    end

    always_comb
    begin
        d = q;
        d.ack = 1'b0;
        case (q.st)
            ST_INIT:
            begin
                // strap capture after reset release
                // slot strap default
                d.ovr.slot = slot_present_strap_i;
                d.ovr.mps = large_payload_strap_i ? MPS_LARGE : MPS_SMALL;
                d.ovr.rber = 1'b1;
                d.st = ST_IDLE;
            end
            ST_IDLE:
            begin
                if (q.start && mem_ready_i)
                begin
                    d.st = ST_MEM;
                end
            end
            ST_MEM:
            begin
                if (mem_rsp_i.done)
                begin
                    d.start = 1'b0;
                    d.st = ST_IDLE;
                    if (!q.cmd)
                    begin
                        d.data = mem_rsp_i.data;
                    end
                end
            end
            default:
            begin
                d.st = ST_IDLE;
            end
        endcase
        if (ovr_valid_i && q.st != ST_INIT)
        begin
            d.ovr = ovr_i;
        end
        if (UPSTREAM && spl_msg_valid_i)
        begin
            d.spl_val = spl_msg_payload_i[7:0];
            d.spl_scl = spl_msg_payload_i[9:8];
        end
        // request taken: word latched, answer next cycle
        if (req && !q.ack)
        begin
            d.ack = 1'b1;
            d.rdata = rd_word;
        end
        if (commit && sel_smem && smem_free)
        begin
            d.start = lane_wdata[START_BIT];
            d.cmd = lane_wdata[CMD_BIT];
            d.addr = lane_wdata[ADDR_LSB+6:ADDR_LSB];
            d.data = lane_wdata[DATA_LSB+15:DATA_LSB];
        end
        else if (commit && sel_ovr && byteenable_i[0])
        begin
            d.ovr = writedata_i[4:0];
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            q.st <= ST_INIT;
            q.start <= 1'b0;
            q.cmd <= 1'b0;
            q.addr <= ADDR_RESET;
            q.data <= DATA_RESET;
            q.ovr <= '0;
            q.spl_val <= SPL_VAL_RESET;
            q.spl_scl <= SPL_SCL_RESET;
            q.rdata <= 32'h0000_0000;
            q.ack <= 1'b0;
        end
        else
        begin
            q <= d;
        end
    end

    assign readdata_o = q.rdata;
    assign waitrequest_o = (read_i || write_i) && !q.ack;
    always_comb
    begin
        mem_req_o.start = (q.st == ST_MEM);
        mem_req_o.write = q.cmd;
        mem_req_o.addr = q.addr;
        mem_req_o.data = q.data;
    end
endmodule

// >>> bench/capreg_bank_monitor.sv
// assertion checker for the capability register slice
`timescale 1ns/1ns
module capreg_bank_monitor
    import capreg_pkg::*;
#(
    parameter bit UPSTREAM = 1'b1,
    parameter int ADDR_W = 8
)(
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic [ADDR_W-1:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [31:0] readdata_o,
    input wire logic waitrequest_o,
    input wire mem_req_s mem_req_o,
    input wire mem_rsp_s mem_rsp_i
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!resetn_i);
    logic rd_ok;
    assign rd_ok = read_i && !waitrequest_o;
    sequence s_ans;
        waitrequest_o ##1 !waitrequest_o;
    endsequence
    sequence s_done;
        mem_req_o.start && mem_rsp_i.done;
    endsequence
    property p_wait;
        (read_i || write_i) && waitrequest_o |-> s_ans;
    endproperty
    property p_hdr_id;
        rd_ok && address_i == ADDR_W'(OFS_HDR)
            |-> readdata_o[15:0] == {NEXT_PTR, CAP_ID};
    endproperty
    property p_hdr_ver;
        rd_ok && address_i == ADDR_W'(OFS_HDR) |-> readdata_o[23:16]
            == {(UPSTREAM ? TYPE_UP : TYPE_DOWN), CAP_VER};
    endproperty
    property p_hdr_msg;
        rd_ok && address_i == ADDR_W'(OFS_HDR) |-> readdata_o[31:25] == 7'h00;
    endproperty
    property p_cap_zero;
        rd_ok && address_i == ADDR_W'(OFS_DEVCAP) |-> readdata_o[14:3]
            == 12'h000 && readdata_o[17:16] == 2'h0;
    endproperty
    property p_unmap;
        rd_ok && address_i == ADDR_W'(OFS_SPL) |-> readdata_o == 32'h0;
    endproperty
    property p_hold;
        mem_req_o.start && !mem_rsp_i.done
            |=> mem_req_o.start && $stable(mem_req_o);
    endproperty
    property p_end;
        s_done |=> !mem_req_o.start;
    endproperty
    a_wait: assert property (p_wait) else $error("no single wait");
    a_hdr_id: assert property (p_hdr_id) else $error("bad id");
    a_hdr_ver: assert property (p_hdr_ver) else $error("bad ver");
    a_hdr_msg: assert property (p_hdr_msg) else $error("bad msg");
    a_cap_zero: assert property (p_cap_zero) else $error("bad cap");
    a_unmap: assert property (p_unmap) else $error("bad rsvd");
    a_hold: assert property (p_hold) else $error("req moved");
    a_end: assert property (p_end) else $error("start stuck");
endmodule
bind capreg_bank capreg_bank_monitor #(.UPSTREAM(UPSTREAM), .ADDR_W(ADDR_W))
    u_mon (.clk_sys_i, .resetn_i, .address_i, .read_i, .write_i,
    .readdata_o, .waitrequest_o, .mem_req_o, .mem_rsp_i);

// >>> bench/capreg_bank_tb_top.sv
// self-checking bench for the capability register slice
`timescale 1ns/1ns
module capreg_bank_tb_top;
    import capreg_pkg::*;
    typedef struct {
        bit wr;
        logic [7:0] adr;
        logic [31:0] wd;
        logic [31:0] msk;
        logic [31:0] exp;
    } row_s;
    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [7:0] address_i = 8'h00;
    logic read_i = 1'b0;
    logic write_i = 1'b0;
    logic [31:0] writedata_i = 32'h0;
    logic [3:0] byteenable_i = 4'hF;
    logic [31:0] readdata_o;
    logic waitrequest_o;
    logic [31:0] readdata_dn;
    logic slot_present_strap_i = 1'b0;
    logic large_payload_strap_i = 1'b1;
    logic ovr_valid_i = 1'b0;
    ovr_s ovr_i = '0;
    logic spl_msg_valid_i = 1'b0;
    logic [9:0] spl_msg_payload_i = 10'h0;
    mem_req_s mem_req_o;
    mem_rsp_s mem_rsp_i = '0;
    logic mem_ready_i = 1'b1;
    int err_count = 0;
    int samples_checked = 0;
    localparam logic [31:0] M = 32'hFFFF_FE03;
    row_s rows [14] = '{
        '{0, 8'hC0, 0, '1, 32'h0052_0010},
        '{1, 8'hC0, '1, 0, 0},
        '{0, 8'hC0, 0, '1, 32'h0052_0010},
        '{0, 8'hC4, 0, '1, 32'h0000_8002},
        '{1, 8'hC4, '1, 0, 0},
        '{0, 8'hC4, 0, '1, 32'h0000_8002},
        '{0, 8'hBC, 0, M, 0},
        '{1, 8'hBC, 32'hA5C3_2A00, 0, 0},
        '{0, 8'hBC, 0, M, 32'hA5C3_2A00},
        '{0, 8'hD4, 0, '1, 0},
        '{0, 8'h40, 0, '1, 0},
        '{1, 8'hD0, 32'h16, 0, 0},
        '{0, 8'hC4, 0, '1, 32'h0000_0003},
        '{0, 8'hC0, 0, '1, 32'h0152_0010}};
    capreg_bank u_dut (.clk_sys_i, .resetn_i, .address_i, .read_i, .write_i,
        .writedata_i, .byteenable_i, .readdata_o, .waitrequest_o,
        .slot_present_strap_i, .large_payload_strap_i, .ovr_valid_i, .ovr_i,
        .spl_msg_valid_i, .spl_msg_payload_i, .mem_req_o, .mem_rsp_i,
        .mem_ready_i);
    capreg_bank #(.UPSTREAM(1'b0)) u_dut_dn (.clk_sys_i, .resetn_i,
        .address_i, .read_i, .write_i, .writedata_i, .byteenable_i,
        .readdata_o(readdata_dn), .waitrequest_o(), .slot_present_strap_i,
        .large_payload_strap_i, .ovr_valid_i, .ovr_i, .spl_msg_valid_i,
        .spl_msg_payload_i, .mem_req_o(), .mem_rsp_i, .mem_ready_i);
    always #10 clk_sys_i = ~clk_sys_i;
    task automatic summarize();
        if (err_count == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic timeout();
        err_count++;
        $display("ERROR %0t: timeout", $time);
        summarize();
    endtask
    task automatic check(logic [31:0] got, logic [31:0] exp, logic [31:0] m);
        samples_checked++;
        if ((got & m) !== (exp & m))
        begin
            err_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(bit wr, logic [7:0] a, logic [31:0] wd,
        output logic [31:0] rd);
        int n;
        @(posedge clk_sys_i);
        address_i <= a;
        writedata_i <= wd;
        read_i <= !wr;
        write_i <= wr;
        for (n = 0; n < 20; n++)
        begin
            @(posedge clk_sys_i);
            if (waitrequest_o === 1'b0)
                break;
        end
        rd = readdata_o;
        read_i <= 1'b0;
        write_i <= 1'b0;
        if (n == 20)
            timeout();
    endtask
    task automatic wait_start();
        int n;
        for (n = 0; n < 20 && mem_req_o.start !== 1'b1; n++)
            @(posedge clk_sys_i);
        if (n == 20)
            timeout();
    endtask
    task automatic pulse_done(logic [15:0] d);
        mem_rsp_i <= {1'b1, d};
        @(posedge clk_sys_i);
        mem_rsp_i <= '0;
    endtask
    task automatic do_reset();
        resetn_i <= 1'b0;
        repeat (5) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
    endtask
    initial
    begin
        logic [31:0] rd;
        do_reset();
        foreach (rows[i])
        begin
            bus(rows[i].wr, rows[i].adr, rows[i].wd, rd);
            if (rows[i].msk != 0)
                check(rd, rows[i].exp, rows[i].msk);
        end
        mem_ready_i <= 1'b0;
        bus(1, 8'hBC, 32'h0000_2A01, rd);
        repeat (3) @(posedge clk_sys_i);
        check({31'h0, mem_req_o.start}, 0, '1);
        mem_ready_i <= 1'b1;
        wait_start();
        check({24'h0, mem_req_o.write, mem_req_o.addr}, 32'h15, '1);
        pulse_done(16'h5A3C);
        bus(0, 8'hBC, 0, rd);
        check(rd, 32'h5A3C_2A00, M);
        bus(1, 8'hBC, 32'h1234_2A03, rd);
        wait_start();
        check(32'({mem_req_o.write, mem_req_o.addr, mem_req_o.data}),
            32'h0095_1234, '1);
        bus(1, 8'hBC, 32'hFFFF_2A00, rd);
        pulse_done(16'hFFFF);
        bus(0, 8'hBC, 0, rd);
        check(rd, 32'h1234_2A02, M);
        byteenable_i <= 4'h4;
        bus(1, 8'hBC, 32'hFFFF_FFFF, rd);
        byteenable_i <= 4'hF;
        bus(0, 8'hBC, 0, rd);
        check(rd, 32'h12FF_2A02, M);
        spl_msg_payload_i <= 10'h27B;
        spl_msg_valid_i <= 1'b1;
        @(posedge clk_sys_i);
        spl_msg_valid_i <= 1'b0;
        bus(0, 8'hC4, 0, rd);
        check(rd, 32'h09EC_0000, 32'h0FFC_0000);
        check(readdata_dn, 0, 32'h0FFC_0000);
        slot_present_strap_i <= 1'b1;
        large_payload_strap_i <= 1'b0;
        do_reset();
        bus(0, 8'hC4, 0, rd);
        check(rd, 32'h0000_8001, '1);
        bus(0, 8'hC0, 0, rd);
        check(rd, 32'h0152_0010, '1);
        check(readdata_dn, 32'h0162_0010, '1);
        bus(0, 8'hBC, 0, rd);
        check(rd, 0, M);
        ovr_i <= '{1'b0, 3'h4, 1'b1};
        ovr_valid_i <= 1'b1;
        @(posedge clk_sys_i);
        ovr_valid_i <= 1'b0;
        bus(0, 8'hC4, 0, rd);
        check(rd, 32'h0000_8004, '1);
        bus(0, 8'hC0, 0, rd);
        check(rd, 32'h0052_0010, '1);
        summarize();
    end
endmodule
